/* design/main_clock_select_prescaler.sv */
// Main clock source selection, system clock prescaler and domain gating.
`timescale 1ns/1ps
module main_clock_select_prescaler (
    // Clock, reset and freeze
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Oscillator and clock pins
    input wire logic osc8_in,
    input wire logic osc128_in,
    input wire logic external_clock_input,
    // Factory calibration byte
    input wire logic [7:0] calibration_byte,
    // Settings writes
    input wire logic instr_tick,
    input wire logic protect_write,
    input wire logic [7:0] protect_data,
    input wire logic main_clock_write,
    input wire logic [1:0] main_clock_data,
    input wire logic prescale_write,
    input wire logic [3:0] prescale_data,
    input wire logic trim_write,
    input wire logic [7:0] trim_data,
    // Domain run requests
    input wire logic core_run,
    input wire logic periph_run,
    input wire logic conv_run,
    // Asynchronous interrupt pin and flag clear
    input wire logic async_int_pin,
    input wire logic async_int_clear,
    // Clock outputs
    output logic main_clock,
    output logic system_clock,
    output logic core_clock,
    output logic peripheral_clock,
    output logic nonvolatile_ctrl_clock,
    output logic converter_clock,
    output logic wdt_clock,
    // Readback and status
    output logic [7:0] main_clock_settings_reg,
    output logic [7:0] prescale_settings_reg,
    output logic [7:0] oscillator_trim_reg,
    output logic switch_busy,
    output logic async_int_seen
);

    typedef struct packed {
        logic [1:0] main_sel;
        logic [3:0] prescale;
        logic [3:0] active_code;
        logic pending;
        logic [7:0] trim;
        logic [2:0] window;
        logic [clock_system_pkg::COUNT_WIDTH-1:0] cnt;
        logic sys_level;
        logic core_gate;
        logic periph_gate;
        logic conv_gate;
        logic core_clk;
        logic periph_clk;
        logic nvm_clk;
        logic conv_clk;
        logic wdt_clk;
        logic int_seen;
    } top_state_type;

    top_state_type st;
    top_state_type next_st;

    logic [clock_system_pkg::PIN_COUNT-1:0] pins;
    logic [clock_system_pkg::PIN_COUNT-1:0] pin_level;
    logic main_level;
    logic main_rise;
    logic busy;
    logic sys_edge;
    logic unlocked;
    logic [clock_system_pkg::COUNT_WIDTH-1:0] cnt_inc;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    assign pins[clock_system_pkg::PIN_OSC8] = osc8_in;
    assign pins[clock_system_pkg::PIN_OSC128] = osc128_in;
    assign pins[clock_system_pkg::PIN_EXT] = external_clock_input;
    assign pins[clock_system_pkg::PIN_INT] = async_int_pin;

    genvar gi;
    generate
        for (gi = 0; gi < clock_system_pkg::PIN_COUNT; gi++) begin : g_sync
            pin_sync u_sync (
                .clk(clk),
                .rst(rst),
                .ce(ce),
                .pin(pins[gi]),
                .level(pin_level[gi])
            );
        end
    endgenerate

    // ************************************************************
    // Source switch
    // ************************************************************
    // one main clock from three sources
    clock_source_switch u_switch (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .src(pin_level[clock_system_pkg::SRC_COUNT-1:0]),
        .req(st.main_sel),
        .main_level(main_level),
        .main_rise(main_rise),
        .busy(busy),
        .active_src()
    );

    // ************************************************************
    // Prescaler decode
    // ************************************************************
    // low count bits spanned by one period
    function automatic logic [clock_system_pkg::COUNT_WIDTH-1:0] div_mask(input logic [3:0] code);
        div_mask = '0;
        for (int i = 0; i < clock_system_pkg::COUNT_WIDTH; i++) begin
            div_mask[i] = (i < int'(code));
        end
    endfunction : div_mask

    // High for the first half of each divided period
    function automatic logic half_high(input logic [clock_system_pkg::COUNT_WIDTH-1:0] c,
                                       input logic [3:0] code);
        logic [clock_system_pkg::COUNT_WIDTH-1:0] m;
        m = div_mask(code);
        half_high = ((c & m) & ~(m >> 1)) == clock_system_pkg::COUNT_ZERO;
    endfunction : half_high

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_st = st;
        cnt_inc = st.cnt + clock_system_pkg::COUNT_ONE;
        unlocked = st.window != clock_system_pkg::WINDOW_CLOSED;
        // counter advances on each main clock rise
        sys_edge = main_rise && ((cnt_inc & div_mask(st.active_code)) ==
                   clock_system_pkg::COUNT_ZERO);
        if (rst) begin
            next_st = '0;
            next_st.main_sel = clock_system_pkg::SRC_OSC8;
            next_st.prescale = clock_system_pkg::PRESCALE_RESET;
            next_st.active_code = clock_system_pkg::PRESCALE_RESET;
            next_st.trim = calibration_byte;
        end else if (ce) begin
            if (protect_write && protect_data == clock_system_pkg::PROTECT_SIGNATURE) begin
                next_st.window = clock_system_pkg::PROTECT_WINDOW;
            end else if (instr_tick && unlocked) begin
                next_st.window = st.window - clock_system_pkg::WINDOW_STEP;
            end
            if (main_rise) begin
                next_st.cnt = sys_edge ? clock_system_pkg::COUNT_ZERO : cnt_inc;
            end
            // new division taken at an old active edge
            if (sys_edge && st.pending) begin
                next_st.active_code = st.prescale;
                next_st.pending = 1'b0;
            end
            if (main_clock_write && unlocked &&
                main_clock_data != clock_system_pkg::SRC_RESERVED) begin
                next_st.main_sel = main_clock_data;
            end
            if (prescale_write && unlocked && prescale_data <= clock_system_pkg::PRESCALE_MAX) begin
                next_st.prescale = prescale_data;
                next_st.pending = 1'b1;
            end
            if (trim_write) begin
                next_st.trim = trim_data;
            end
            // level restarts high only at active edges
            if (st.active_code == clock_system_pkg::PRESCALE_DIV1 &&
                next_st.active_code == clock_system_pkg::PRESCALE_DIV1) begin
                next_st.sys_level = main_level;
            end else begin
                next_st.sys_level = half_high(next_st.cnt, next_st.active_code);
            end
            // gates change only while system clock low
            if (!next_st.sys_level) begin
                next_st.core_gate = core_run;
                next_st.periph_gate = periph_run;
                next_st.conv_gate = conv_run;
            end
            // core sees no edges when gated
            next_st.core_clk = next_st.sys_level && next_st.core_gate;
            next_st.nvm_clk = next_st.sys_level && next_st.core_gate;
            next_st.periph_clk = next_st.sys_level && next_st.periph_gate;
            next_st.conv_clk = next_st.sys_level && next_st.conv_gate;
            next_st.wdt_clk = pin_level[clock_system_pkg::PIN_OSC128];
            // interrupt caught regardless of gating; set wins
            if (pin_level[clock_system_pkg::PIN_INT]) begin
                next_st.int_seen = 1'b1;
            end else if (async_int_clear) begin
                next_st.int_seen = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign main_clock = main_level;
    assign system_clock = st.sys_level;
    assign core_clock = st.core_clk;
    assign peripheral_clock = st.periph_clk;
    assign nonvolatile_ctrl_clock = st.nvm_clk;
    assign converter_clock = st.conv_clk;
    assign wdt_clock = st.wdt_clk;
    assign main_clock_settings_reg = {6'h00, st.main_sel};
    assign prescale_settings_reg = {4'h0, st.prescale};
    assign oscillator_trim_reg = st.trim;
    assign switch_busy = busy;
    assign async_int_seen = st.int_seen;

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_locked_write;
        ce && main_clock_write && st.window == clock_system_pkg::WINDOW_CLOSED;
    endsequence

    a_reset_source: assert property (@(posedge clk)
        rst |=> st.main_sel == clock_system_pkg::SRC_OSC8)
        else $error("main source not 8 MHz after reset");

    a_reset_div: assert property (@(posedge clk)
        rst |=> st.active_code == clock_system_pkg::PRESCALE_RESET && !st.pending)
        else $error("prescaler not divide by 8 after reset");

    a_trim_load: assert property (@(posedge clk)
        rst |=> st.trim == $past(calibration_byte))
        else $error("calibration byte not loaded into trim");

    a_locked_write: assert property (@(posedge clk) disable iff (rst)
        s_locked_write |=> $stable(st.main_sel))
        else $error("source changed without unlock");

    a_reserved_code: assert property (@(posedge clk) disable iff (rst)
        ce && prescale_write && prescale_data > clock_system_pkg::PRESCALE_MAX
        |=> $stable(st.prescale))
        else $error("reserved prescale code accepted");

    // division switches on old active edge
    a_apply_edge: assert property (@(posedge clk) disable iff (rst)
        $changed(st.active_code) |-> $past(sys_edge) && $past(st.pending))
        else $error("division changed away from an active edge");

    // gated core gets no high level
    a_core_stop: assert property (@(posedge clk) disable iff (rst)
        !st.core_gate |-> !st.core_clk && !st.nvm_clk)
        else $error("core clock high while gated");

    a_wdt_free: assert property (@(posedge clk) disable iff (rst)
        ce ##1 ce |-> st.wdt_clk == $past(pin_level[clock_system_pkg::PIN_OSC128]))
        else $error("watchdog clock not following 128 kHz oscillator");

    // gate only changes while clock low
    a_gate_low: assert property (@(posedge clk) disable iff (rst)
        $changed(st.periph_gate) |-> !st.sys_level)
        else $error("peripheral gate changed with clock high");

    sequence s_apply_edge;
        ce && st.pending && sys_edge && !prescale_write;
    endsequence

    // pending code taken at the edge
    a_pending_apply: assert property (@(posedge clk) disable iff (rst)
        s_apply_edge |=> !st.pending && st.active_code == $past(st.prescale))
        else $error("pending division not applied at the active edge");

    // new period starts high from zero
    a_restart_count: assert property (@(posedge clk) disable iff (rst)
        s_apply_edge |=> st.cnt == clock_system_pkg::COUNT_ZERO && st.sys_level)
        else $error("count not restarted at the active edge");

    a_unlock_open: assert property (@(posedge clk) disable iff (rst)
        ce && protect_write && protect_data == clock_system_pkg::PROTECT_SIGNATURE
        |=> st.window == clock_system_pkg::PROTECT_WINDOW)
        else $error("signature did not open the change window");

    a_int_set: assert property (@(posedge clk) disable iff (rst)
        ce && pin_level[clock_system_pkg::PIN_INT] |=> st.int_seen)
        else $error("interrupt level did not set the flag");

endmodule : main_clock_select_prescaler

/* design/clock_system_pkg.sv */
// Constants, types and encodings shared by the main clock selector and prescaler.
// Notes on behaviour
// - With the core clock stopped the core and its memories see no edges.
// - Some external interrupts are caught even while the peripheral clock is stopped.
// - The nonvolatile-controller clock runs whenever the core clock runs.
// - The converter clock is gated on its own, independent of core and peripheral.
// - Every synchronous clock derives from the one main clock of three sources.
// - Select code 00 picks 8 MHz, 01 picks 128 kHz, 10 picks external.
// - During reset the factory calibration byte is copied into the trim register.
// - The 128 kHz oscillator keeps clocking the watchdog whatever source is main.
// - Changing the main source produces no runt pulse on the main clock.
// - After reset the 8 MHz oscillator is the main clock source.
// - After reset the system clock is the main clock divided by 8.
// - The prescaler works with every source and clocks core and peripherals.
// - A prescaler change is glitch-free, no period shorter than old or new.
// - The prescaler is a counter at the main clock rate, not readable.
// - New division is active between T1+T2 and T1+2*T2 after the write; here it applies at the next old active edge, within T1.
// - Exactly two active system clock edges occur in the transition interval.
// - Prescale code n divides by 2**n for 0..8, resets to 0011, rest reserved.
// - Source and prescale writes count only within four instruction cycles of unlock.
package clock_system_pkg;

    // ************************************************************
    // Source codes and pin indices
    // ************************************************************
    localparam logic [1:0] SRC_OSC8 = 2'h0;
    localparam logic [1:0] SRC_OSC128 = 2'h1;
    localparam logic [1:0] SRC_EXT = 2'h2;
    localparam logic [1:0] SRC_RESERVED = 2'h3;
    localparam int PIN_OSC8 = 0;
    localparam int PIN_OSC128 = 1;
    localparam int PIN_EXT = 2;
    localparam int PIN_INT = 3;
    localparam int PIN_COUNT = 4;
    localparam int SRC_COUNT = 3;

    // ************************************************************
    // Prescaler and settings
    // ************************************************************
    localparam int COUNT_WIDTH = 8;
    localparam logic [3:0] PRESCALE_RESET = 4'h3;
    localparam logic [3:0] PRESCALE_MAX = 4'h8;
    localparam logic [3:0] PRESCALE_DIV1 = 4'h0;
    localparam logic [COUNT_WIDTH-1:0] COUNT_ONE = 8'h01;
    localparam logic [COUNT_WIDTH-1:0] COUNT_ZERO = 8'h00;
    localparam logic [2:0] PROTECT_WINDOW = 3'h4;
    localparam logic [2:0] WINDOW_CLOSED = 3'h0;
    localparam logic [2:0] WINDOW_STEP = 3'h1;
    // Unlock signature value is arbitrary
    localparam logic [7:0] PROTECT_SIGNATURE = 8'hA5;
    localparam logic [7:0] TRIM_RESET = 8'h00;

    // ************************************************************
    // Source switch states
    // ************************************************************
    typedef enum logic [1:0] {
        SW_RUN = 2'b00,
        SW_WAIT_LOW = 2'b01,
        SW_WAIT_RISE = 2'b10
    } switch_state_type;

endpackage : clock_system_pkg

/* design/pin_sync.sv */
// Three-stage synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module pin_sync (
    // Clock and control
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Asynchronous pin and its clean level
    input wire logic pin,
    output logic level
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } sync_state_type;

    sync_state_type st;
    sync_state_type next_st;

    always_comb begin
        next_st = st;
        if (rst) begin
            next_st = '0;
        end else if (ce) begin
            next_st.s1 = pin;
            next_st.s2 = st.s1;
            next_st.s3 = st.s2;
            if (st.s2 == st.s3) begin
                next_st.q = st.s2;
            end
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    assign level = st.q;

    // ************************************************************
    // Checks
    // ************************************************************
    // clean level moves only on agreement
    a_sync_agree: assert property (@(posedge clk) disable iff (rst)
        $changed(st.q) |-> $past(st.s2) == $past(st.s3) && st.q == $past(st.s3))
        else $error("synchronised level changed without stage agreement");

endmodule : pin_sync

/* design/clock_source_switch.sv */
// Glitch-free selector that moves the main clock between the two oscillators and the external clock.
`timescale 1ns/1ps
module clock_source_switch (
    // Clock and control
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Synchronised source levels and requested source
    input wire logic [2:0] src,
    input wire logic [1:0] req,
    // Main clock
    output logic main_level,
    output logic main_rise,
    output logic busy,
    output logic [1:0] active_src
);

    typedef struct packed {
        clock_system_pkg::switch_state_type state;
        logic [1:0] cur;
        logic [1:0] tgt;
        logic level;
        logic rise;
        logic busy;
    } switch_reg_type;

    switch_reg_type st;
    switch_reg_type next_st;

    function automatic logic pick(input logic [2:0] lv, input logic [1:0] sel);
        pick = (sel == clock_system_pkg::SRC_RESERVED) ? 1'b0 : lv[sel];
    endfunction : pick

    always_comb begin
        next_st = st;
        if (rst) begin
            next_st.state = clock_system_pkg::SW_RUN;
            next_st.cur = clock_system_pkg::SRC_OSC8;
            next_st.tgt = clock_system_pkg::SRC_OSC8;
            next_st.level = 1'b0;
            next_st.rise = 1'b0;
            next_st.busy = 1'b0;
        end else if (ce) begin
            unique case (st.state)
                clock_system_pkg::SW_RUN: begin
                    next_st.level = pick(src, st.cur);
                    // leave old source only while it is low
                    if (req != st.cur && !pick(src, st.cur)) begin
                        next_st.state = clock_system_pkg::SW_WAIT_LOW;
                        next_st.tgt = req;
                        next_st.level = 1'b0;
                    end
                end
                clock_system_pkg::SW_WAIT_LOW: begin
                    next_st.level = 1'b0;
                    if (!pick(src, st.tgt)) begin
                        next_st.state = clock_system_pkg::SW_WAIT_RISE;
                    end
                end
                clock_system_pkg::SW_WAIT_RISE: begin
                    next_st.level = 1'b0;
                    // reconnect on a clean rising edge
                    if (pick(src, st.tgt)) begin
                        next_st.state = clock_system_pkg::SW_RUN;
                        next_st.cur = st.tgt;
                        next_st.level = 1'b1;
                    end
                end
                default: begin
                    next_st.state = clock_system_pkg::SW_RUN;
                    next_st.level = 1'b0;
                end
            endcase
            next_st.rise = next_st.level && !st.level;
            next_st.busy = next_st.state != clock_system_pkg::SW_RUN;
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    assign main_level = st.level;
    assign main_rise = st.rise;
    assign busy = st.busy;
    assign active_src = st.cur;

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_new_edge;
        ce && st.state == clock_system_pkg::SW_WAIT_RISE && pick(src, st.tgt);
    endsequence

    a_park_low: assert property (@(posedge clk) disable iff (rst)
        st.state != clock_system_pkg::SW_RUN |-> !st.level)
        else $error("main clock not low during source switch");

    a_connect_edge: assert property (@(posedge clk) disable iff (rst)
        s_new_edge |=> st.state == clock_system_pkg::SW_RUN && st.level && st.rise)
        else $error("new source not connected on its rising edge");

    // no cut of a high phase
    a_no_runt: assert property (@(posedge clk) disable iff (rst)
        $rose(st.busy) |-> !st.level && !$past(pick(src, st.cur)))
        else $error("switch started while old source high");

endmodule : clock_source_switch

/* bench/ext_clock_source.sv */
// Model of the external clock driver on the clock input pin.
`timescale 1ns/1ps
module ext_clock_source #(
    parameter real HALF_NS = 14.0
) (
    // Clock pin
    output logic ext_clk
);
    initial begin
        ext_clk = 1'h0;
        #1.3;
        forever #(HALF_NS) ext_clk = ~ext_clk;
    end
endmodule : ext_clock_source

/* bench/main_clock_select_prescaler_tb.sv */
// Self-checking bench for the main clock selector and prescaler.
`timescale 1ns/1ps
module main_clock_select_prescaler_tb;
    logic clk = 1'h0, rst = 1'h1, ce = 1'h1, osc8_in = 1'h0, osc128_in = 1'h0;
    logic external_clock_input, instr_tick = 1'h0, protect_write = 1'h0, trim_write = 1'h0;
    logic main_clock_write = 1'h0, prescale_write = 1'h0, async_int_pin = 1'h0;
    logic [7:0] calibration_byte = 8'h5C, protect_data = 8'h00, trim_data = 8'h00;
    logic [1:0] main_clock_data = 2'h0;
    logic [3:0] prescale_data = 4'h0;
    logic [4:0] last = 5'h1F;
    logic core_run = 1'h1, periph_run = 1'h1, conv_run = 1'h1, async_int_clear = 1'h0;
    logic main_clock, system_clock, core_clock, peripheral_clock, nonvolatile_ctrl_clock;
    logic converter_clock, wdt_clock, switch_busy, async_int_seen;
    logic [7:0] main_clock_settings_reg, prescale_settings_reg, oscillator_trim_reg;
    logic [7:0] code[4] = '{8'h01, 8'h02, 8'h03, 8'h00};
    logic [7:0] expv[4] = '{8'h01, 8'h02, 8'h02, 8'h00};
    int per[4] = '{30, 7, 7, 10};
    int n_mismatch = 0, n_compared = 0, m, c, cnt[5];
    wire logic [4:0] taps = {peripheral_clock, wdt_clock, converter_clock,
        nonvolatile_ctrl_clock, core_clock};

    always #2 clk = ~clk;
    initial begin
        #1.1;
        forever #20 osc8_in = ~osc8_in;
    end
    initial begin
        #0.7;
        forever #60 osc128_in = ~osc128_in;
    end
    always @(posedge clk) begin
        last <= taps;
        for (int i = 0; i < 5; i++) cnt[i] += (taps[i] && !last[i]);
    end

    ext_clock_source ext (.ext_clk(external_clock_input));
    main_clock_select_prescaler dut (.clk, .rst, .ce, .osc8_in, .osc128_in,
        .external_clock_input, .calibration_byte, .instr_tick, .protect_write, .protect_data,
        .main_clock_write, .main_clock_data, .prescale_write, .prescale_data, .trim_write,
        .trim_data, .core_run, .periph_run, .conv_run, .async_int_pin, .async_int_clear,
        .main_clock, .system_clock, .core_clock, .peripheral_clock, .nonvolatile_ctrl_clock,
        .converter_clock, .wdt_clock, .main_clock_settings_reg, .prescale_settings_reg,
        .oscillator_trim_reg, .switch_busy, .async_int_seen);

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_n(input int got, input int exp);
        n_compared++;
        if (got != exp) begin
            n_mismatch++;
            $display("[FAIL] %0t count %0d expected %0d", $time, got, exp);
        end
    endtask : chk_n
    // Kinds: 0 unlock, 1 source, 2 prescale, 3 trim, 4 instruction tick
    task automatic wr(input int k, input logic [7:0] d);
        @(negedge clk);
        case (k)
            0: begin protect_write = 1'h1; protect_data = d; end
            1: begin main_clock_write = 1'h1; main_clock_data = d[1:0]; end
            2: begin prescale_write = 1'h1; prescale_data = d[3:0]; end
            3: begin trim_write = 1'h1; trim_data = d; end
            default: instr_tick = 1'h1;
        endcase
        @(negedge clk);
        {protect_write, main_clock_write, prescale_write, trim_write, instr_tick} = 5'h00;
        @(negedge clk);
    endtask : wr
    // Main rises and clk cycles within one system clock period
    task automatic measure(output int mains, output int clks);
        logic ps, pm;
        int g, e;
        mains = 0;
        clks = 0;
        g = 0;
        e = 0;
        ps = system_clock;
        while (e < 2 && g < 9000) begin
            @(negedge clk);
            g++;
            if (e == 1) begin
                clks++;
                mains += (main_clock && !pm);
            end
            e += (system_clock && !ps);
            ps = system_clock;
            pm = main_clock;
        end
        if (g >= 9000) begin
            n_mismatch++;
        end
    endtask : measure
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report

    initial begin
        #240000;
        n_mismatch++;
        final_report();
    end

    initial begin
        repeat (20) @(negedge clk);
        rst = 1'h0;
        chk(main_clock_settings_reg, 8'h00);
        chk(prescale_settings_reg, 8'h03);
        chk(oscillator_trim_reg, 8'h5C);
        measure(m, c);
        measure(m, c);
        chk_n(m, 8);
        $display("test reset done");
        wr(1, 8'h01);
        chk(main_clock_settings_reg, 8'h00);
        wr(2, 8'h01);
        chk(prescale_settings_reg, 8'h03);
        wr(0, 8'hA5);
        repeat (4) wr(4, 8'h00);
        wr(2, 8'h01);
        chk(prescale_settings_reg, 8'h03);
        wr(0, 8'hA5);
        repeat (3) wr(4, 8'h00);
        wr(2, 8'h09);
        chk(prescale_settings_reg, 8'h03);
        wr(2, 8'h08);
        chk(prescale_settings_reg, 8'h08);
        $display("test protection done");
        for (int k = 0; k <= 8; k++) begin
            wr(0, 8'hA5);
            wr(2, k[7:0]);
            measure(m, c);
            measure(m, c);
            chk_n(m, 1 << k);
            chk_n(c, 10 << k);
        end
        $display("test division done");
        wr(0, 8'hA5);
        wr(2, 8'h01);
        for (int i = 0; i < 4; i++) begin
            wr(0, 8'hA5);
            wr(1, code[i]);
            for (int g = 0; g < 300 && switch_busy !== 1'h0; g++) @(negedge clk);
            if (switch_busy !== 1'h0) begin
                n_mismatch++;
            end
            measure(m, c);
            measure(m, c);
            chk(main_clock_settings_reg, expv[i]);
            chk_n(c, 2 * per[i]);
            chk_n(m, 2);
        end
        $display("test source done");
        core_run = 1'h0;
        periph_run = 1'h0;
        repeat (40) @(negedge clk);
        cnt = '{default: 0};
        repeat (400) @(negedge clk);
        chk_n(cnt[0], 0);
        chk_n(cnt[1], 0);
        chk_n(cnt[2], 20);
        chk_n(cnt[3] > 0, 1);
        chk_n(cnt[4], 0);
        async_int_pin = 1'h1;
        repeat (6) @(negedge clk);
        chk({7'h00, async_int_seen}, 8'h01);
        async_int_pin = 1'h0;
        repeat (6) @(negedge clk);
        async_int_clear = 1'h1;
        @(negedge clk);
        async_int_clear = 1'h0;
        @(negedge clk);
        chk({7'h00, async_int_seen}, 8'h00);
        core_run = 1'h1;
        periph_run = 1'h1;
        repeat (40) @(negedge clk);
        cnt = '{default: 0};
        repeat (400) @(negedge clk);
        chk_n(cnt[0], 20);
        chk_n(cnt[1], cnt[0]);
        chk_n(cnt[4], 20);
        wr(3, 8'h3A);
        chk(oscillator_trim_reg, 8'h3A);
        $display("test gating done");
        final_report();
    end
endmodule : main_clock_select_prescaler_tb
